// >>> rtl/hpsc_consts.svh
// Purpose: offsets, field positions and reset values of the slot control
// Assumes: 32-bit APB data, word-aligned registers
// Notes: included by the slot control module; definitions only
`ifndef HPSC_CONSTS_SVH
`define HPSC_CONSTS_SVH

// register byte offsets
`define HPSC_OFF_CTL 12'h000
`define HPSC_OFF_CAP 12'h004
`define HPSC_OFF_STS 12'h008
`define HPSC_OFF_CFG 12'h00C

// slot control field positions
`define HPSC_CTL_LATCH_EN 2
`define HPSC_CTL_PRES_EN 3
`define HPSC_CTL_CMD_EN 4
`define HPSC_CTL_HOTPLUG_IRQ_EN 5
`define HPSC_CTL_ATT_LO 6
`define HPSC_CTL_ATT_HI 7
`define HPSC_CTL_PWR_LO 8
`define HPSC_CTL_PWR_HI 9
`define HPSC_CTL_PWRCTL 10
`define HPSC_CTL_ILK 11
`define HPSC_CTL_LINK_EN 12

// slot control reset value: attention off, power indicator on
`define HPSC_CTL_RESET 16'h01C0

// indicator codes
`define HPSC_LED_ON 2'h1
`define HPSC_LED_BLINK 2'h2
`define HPSC_LED_OFF 2'h3
`define HPSC_ATT_RESET 2'h3
`define HPSC_PWR_RESET 2'h1

// slot capabilities field positions
`define HPSC_CAP_PCP 1
`define HPSC_CAP_MRLP 2
`define HPSC_CAP_ATTENTION_LED_PRESENT 3
`define HPSC_CAP_POWER_LED_PRESENT 4
`define HPSC_CAP_HPC 6
`define HPSC_CAP_EIP 17
`define HPSC_CAP_WMASK 32'h0002005E

// slot status field positions
`define HPSC_STS_LATCH_CHG 2
`define HPSC_STS_PRES_CHG 3
`define HPSC_STS_CMD_DONE 4
`define HPSC_STS_LATCH 5
`define HPSC_STS_PRES 6
`define HPSC_STS_ILK 7
`define HPSC_STS_LINK_CHG 8

// configuration field positions
`define HPSC_CFG_UPSTREAM 0

`endif

// >>> rtl/hpsc_pkg.sv
// Purpose: types shared by the slot control block
// Assumes: nothing beyond the constants header
// Notes: states carry no explicit codes
package hpsc_pkg;

   // command sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_APPLY,
      SEQ_WAIT
   } hpsc_seq_e;

   // slot event indices for the change detector
   typedef enum int {
      EVT_LATCH = 0,
      EVT_PRES = 1,
      EVT_LINK = 2
   } hpsc_evt_e;

endpackage : hpsc_pkg

// >>> rtl/hpsc_evt_det.sv
// Purpose: flags a state change on each slot sensor input
// Assumes: inputs synchronous to pclk
// Notes: first cycle after reset only loads the history
module hpsc_evt_det
   import hpsc_pkg::*;
#(
   parameter int N = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] sense,
   output logic [N-1:0] change
);

   logic armed_r;
   logic [N-1:0] prev_r;
   logic [N-1:0] change_r;

   // arm after first sample so reset history gives no false change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_r <= 1'b0;
      end else begin
         armed_r <= 1'b1;
      end
   end

   // per-input history and change pulse
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prev_r[i] <= 1'b0;
               change_r[i] <= 1'b0;
            end else begin
               prev_r[i] <= sense[i];
               change_r[i] <= armed_r & (sense[i] ^ prev_r[i]);
            end
         end
      end
   endgenerate

   assign change = change_r;

endmodule : hpsc_evt_det

// >>> rtl/hpsc_cmd_seq.sv
// Purpose: tracks one slot control command until its actions finish
// Assumes: ack is a pulse from the slot controller after an update
// Notes: a new start restarts the wait for the pending command
module hpsc_cmd_seq
   import hpsc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic ack,
   output logic update,
   output logic done,
   output logic busy
);

   hpsc_seq_e state_r, state_nxt;
   logic update_r;
   logic done_r;

   // next state: apply for one cycle, then wait for the slot ack
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SEQ_IDLE: begin
            if (start) begin
               state_nxt = SEQ_APPLY;
            end
         end
         SEQ_APPLY: begin
            state_nxt = start ? SEQ_APPLY : SEQ_WAIT;
         end
         SEQ_WAIT: begin
            if (start) begin
               state_nxt = SEQ_APPLY;
            end else if (ack) begin
               state_nxt = SEQ_IDLE;
            end
         end
         default: begin
            state_nxt = SEQ_IDLE;
         end
      endcase
   end

   // state and one-cycle strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= SEQ_IDLE;
         update_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         update_r <= (state_nxt == SEQ_APPLY);
         done_r <= (state_r == SEQ_WAIT) & ack & ~start;
      end
   end

   assign update = update_r;
   assign done = done_r;
   assign busy = (state_r != SEQ_IDLE);

endmodule : hpsc_cmd_seq

// >>> rtl/hpsc_slot_ctl.sv
// Purpose: hot-plug slot control register upper bits with APB access
// Assumes: slot sensor inputs synchronous to pclk; ack pulse from slot
// Notes: slot control, capabilities, status and config words on APB
//
// Notes on behaviour
// - latch sensor change raises event when enabled
// - presence change raises event when enabled
// - finished command raises interrupt when enabled
// - master enable gates all hot-plug interrupts
// - attention field drives indicator, resets off
// - attention field reads zero without indicator
// - power field drives indicator, resets on
// - power field reads zero without indicator
// - upstream port ignores power indicator writes
// - power control bit sets slot power
// - interlock bit always reads zero
// - writing one toggles interlock when present
// - link active change raises event when enabled
// - gated fields read-only zero without capability
// - one write is one command, then done
//
// Implementation choices: the APB register port and the register offsets.
`include "hpsc_consts.svh"

module hpsc_slot_ctl
   import hpsc_pkg::*;
#(
   parameter int AW = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic latch_open,
   input wire logic card_present,
   input wire logic link_active,
   input wire logic slot_ack,
   output logic [1:0] attention_led,
   output logic [1:0] power_led,
   output logic slot_power_off,
   output logic interlock_engaged,
   output logic slot_update,
   output logic hp_irq,
   output logic hp_wake
);

   // registers
   logic [15:0] ctl_r, ctl_nxt;
   logic [31:0] cap_r, cap_nxt;
   logic [3:0] flags_r, flags_nxt;
   logic upstream_r;
   logic interlock_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [1:0] att_out_r;
   logic [1:0] pwr_out_r;
   logic pwr_off_r;
   logic irq_r;
   logic wake_r;

   // bus decode
   wire access = psel & penable;
   wire take = access & pready_r;
   wire wr = take & pwrite;
   wire hit_ctl = (paddr == AW'(`HPSC_OFF_CTL));
   wire hit_cap = (paddr == AW'(`HPSC_OFF_CAP));
   wire hit_sts = (paddr == AW'(`HPSC_OFF_STS));
   wire hit_cfg = (paddr == AW'(`HPSC_OFF_CFG));
   wire mapped = hit_ctl | hit_cap | hit_sts | hit_cfg;
   wire wr_ctl = wr & hit_ctl;
   wire wr_cap = wr & hit_cap;
   wire wr_sts = wr & hit_sts;
   wire wr_cfg = wr & hit_cfg;

   // byte lane mask from the strobes
   wire [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                            {8{pstrb[1]}}, {8{pstrb[0]}}};

   // capability decode
   wire cap_pcp = cap_r[`HPSC_CAP_PCP];
   wire cap_mrlp = cap_r[`HPSC_CAP_MRLP];
   wire cap_attention_led_present = cap_r[`HPSC_CAP_ATTENTION_LED_PRESENT];
   wire cap_power_led_present = cap_r[`HPSC_CAP_POWER_LED_PRESENT];
   wire cap_hpc = cap_r[`HPSC_CAP_HPC];
   wire cap_eip = cap_r[`HPSC_CAP_EIP];

   // stored control bits that software may change now
   logic [15:0] ctl_live;
   always_comb begin
      ctl_live = 16'h0000;
      ctl_live[`HPSC_CTL_LATCH_EN] = cap_mrlp;
      ctl_live[`HPSC_CTL_PRES_EN] = 1'b1;
      ctl_live[`HPSC_CTL_CMD_EN] = cap_hpc;
      ctl_live[`HPSC_CTL_HOTPLUG_IRQ_EN] = cap_hpc;
      ctl_live[`HPSC_CTL_ATT_HI] = cap_attention_led_present;
      ctl_live[`HPSC_CTL_ATT_LO] = cap_attention_led_present;
      ctl_live[`HPSC_CTL_PWR_HI] = cap_power_led_present;
      ctl_live[`HPSC_CTL_PWR_LO] = cap_power_led_present;
      ctl_live[`HPSC_CTL_PWRCTL] = cap_pcp;
      ctl_live[`HPSC_CTL_LINK_EN] = 1'b1;
   end

   // control write: only live bits in written lanes change
   wire [15:0] ctl_wmask = ctl_live & lane_mask[15:0];
   always_comb begin
      ctl_nxt = ctl_r;
      if (wr_ctl) begin
         ctl_nxt = (ctl_r & ~ctl_wmask) | (pwdata[15:0] & ctl_wmask);
      end
   end

   // control read view: gated and fixed-zero bits masked
   wire [15:0] ctl_view = ctl_r & ctl_live;

   // field views used by the slot logic
   wire latch_en = ctl_view[`HPSC_CTL_LATCH_EN];
   wire pres_en = ctl_view[`HPSC_CTL_PRES_EN];
   wire cmd_en = ctl_view[`HPSC_CTL_CMD_EN];
   wire hotplug_irq_en = ctl_view[`HPSC_CTL_HOTPLUG_IRQ_EN];
   wire link_en = ctl_view[`HPSC_CTL_LINK_EN];
   wire [1:0] att_fld = ctl_view[`HPSC_CTL_ATT_HI:`HPSC_CTL_ATT_LO];
   wire [1:0] pwr_fld = ctl_nxt[`HPSC_CTL_PWR_HI:`HPSC_CTL_PWR_LO];
   wire pwr_ctl = ctl_view[`HPSC_CTL_PWRCTL];

   // interlock toggle request: a one in bit 11 of the written lane
   wire ilk_toggle = wr_ctl & pstrb[1] & pwdata[`HPSC_CTL_ILK] & cap_eip;

   // capability register writes
   wire [31:0] cap_wmask = `HPSC_CAP_WMASK & lane_mask;
   always_comb begin
      cap_nxt = cap_r;
      if (wr_cap) begin
         cap_nxt = (cap_r & ~cap_wmask) | (pwdata & cap_wmask);
      end
   end

   // sensor change detection
   logic [2:0] sense;
   logic [2:0] change;
   always_comb begin
      sense = 3'h0;
      sense[EVT_LATCH] = latch_open;
      sense[EVT_PRES] = card_present;
      sense[EVT_LINK] = link_active;
   end

   hpsc_evt_det #(
      .N(3)
   ) u_evt (
      .pclk(pclk),
      .presetn(presetn),
      .sense(sense),
      .change(change)
   );

   // command tracking for each control write
   logic seq_done;
   logic seq_update;
   hpsc_cmd_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .start(wr_ctl),
      .ack(slot_ack),
      .update(seq_update),
      .done(seq_done),
      .busy()
   );

   // sticky flags: 0 latch, 1 presence, 2 command, 3 link
   wire [3:0] flag_set = {change[EVT_LINK], seq_done,
                          change[EVT_PRES], change[EVT_LATCH]};
   wire [3:0] flag_clr_req = {pwdata[`HPSC_STS_LINK_CHG],
                              pwdata[`HPSC_STS_CMD_DONE],
                              pwdata[`HPSC_STS_PRES_CHG],
                              pwdata[`HPSC_STS_LATCH_CHG]};
   wire [3:0] flag_lane = {pstrb[1], pstrb[0], pstrb[0], pstrb[0]};
   wire [3:0] flag_clr = {4{wr_sts}} & flag_clr_req & flag_lane;

   // write one to clear; a new event in the same cycle wins
   always_comb begin
      flags_nxt = (flags_r & ~flag_clr) | flag_set;
   end

   // enabled events
   wire ev_latch = flags_r[0] & latch_en;
   wire ev_pres = flags_r[1] & pres_en;
   wire ev_cmd = flags_r[2] & cmd_en;
   wire ev_link = flags_r[3] & link_en;
   wire ev_any = ev_latch | ev_pres | ev_link;

   // status read view
   logic [31:0] sts_view;
   always_comb begin
      sts_view = 32'h0000_0000;
      sts_view[`HPSC_STS_LATCH_CHG] = flags_r[0];
      sts_view[`HPSC_STS_PRES_CHG] = flags_r[1];
      sts_view[`HPSC_STS_CMD_DONE] = flags_r[2];
      sts_view[`HPSC_STS_LINK_CHG] = flags_r[3];
      sts_view[`HPSC_STS_LATCH] = latch_open;
      sts_view[`HPSC_STS_PRES] = card_present;
      sts_view[`HPSC_STS_ILK] = interlock_r;
   end

   // read data select
   wire [31:0] cfg_view = {31'h0000_0000, upstream_r};
   wire [31:0] rd_mux = hit_ctl ? {16'h0000, ctl_view} :
                        hit_cap ? cap_r :
                        hit_sts ? sts_view :
                        hit_cfg ? cfg_view : 32'h0000_0000;

   // apb answer: one wait cycle, then pready with data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= access & ~pready_r;
         pslverr_r <= access & ~pready_r & ~mapped;
         prdata_r <= (access & ~pready_r & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // control, capability and config storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= `HPSC_CTL_RESET;
         cap_r <= 32'h0000_0000;
         upstream_r <= 1'b0;
      end else begin
         ctl_r <= ctl_nxt;
         cap_r <= cap_nxt;
         if (wr_cfg & pstrb[0]) begin
            upstream_r <= pwdata[`HPSC_CFG_UPSTREAM];
         end
      end
   end

   // sticky status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= 4'h0;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // interlock state flips on each accepted toggle write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interlock_r <= 1'b0;
      end else if (ilk_toggle) begin
         interlock_r <= ~interlock_r;
      end
   end

   // attention indicator follows its field; off without the indicator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         att_out_r <= `HPSC_ATT_RESET;
      end else begin
         att_out_r <= cap_attention_led_present ? att_fld : `HPSC_LED_OFF;
      end
   end

   // power indicator moves only on a write at a downstream port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_out_r <= `HPSC_PWR_RESET;
      end else if (wr_ctl & cap_power_led_present & ~upstream_r) begin
         pwr_out_r <= pwr_fld;
      end
   end

   // slot power: one means off, on while no controller
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_off_r <= 1'b0;
      end else begin
         pwr_off_r <= pwr_ctl;
      end
   end

   // interrupt gated by master enable, wake-up by event enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         irq_r <= hotplug_irq_en & (ev_any | ev_cmd);
         wake_r <= ev_any;
      end
   end

   // outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign attention_led = att_out_r;
   assign power_led = pwr_out_r;
   assign slot_power_off = pwr_off_r;
   assign interlock_engaged = interlock_r;
   assign slot_update = seq_update;
   assign hp_irq = irq_r;
   assign hp_wake = wake_r;

endmodule : hpsc_slot_ctl

// >>> testbench/hpsc_slot_ctl_assertions.sv
// Purpose: port-level checks of the slot control block
// Assumes: APB master holds requests until pready
// Notes: bound into hpsc_slot_ctl at the foot of this file
module hpsc_slot_ctl_assertions #(
   parameter int AW = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] power_led,
   input wire logic interlock_engaged,
   input wire logic slot_update
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // address decode seen by the checker
   wire unmapped = (paddr > 12'h00C) || (paddr[1:0] != 2'h0);

   // bus phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_ctl_wr;
      psel && penable && pready && pwrite && paddr == 12'h000;
   endsequence

   property p_acc;
      s_setup |=> !pready ##1 pready;
   endproperty
   property p_rdy_one;
      pready |=> !pready;
   endproperty
   property p_rdy_cause;
      pready |-> psel && penable;
   endproperty
   property p_err;
      pready |-> pslverr == unmapped;
   endproperty
   property p_rd_ctl;
      pready && !pwrite && paddr == 12'h000 |-> (prdata & 32'hFFFFE803) == 0;
   endproperty
   property p_upd;
      s_ctl_wr |=> slot_update ##1 !slot_update;
   endproperty
   property p_upd_cause;
      slot_update |-> $past(psel && penable && pready && pwrite
                            && paddr == 12'h000);
   endproperty
   property p_ilk;
      !$stable(interlock_engaged) |-> slot_update;
   endproperty
   property p_pled;
      !$stable(power_led) |-> slot_update;
   endproperty

   a_acc: assert property (p_acc) else $error("access length wrong");
   a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
   a_rdy_cause: assert property (p_rdy_cause) else $error("stray pready");
   a_err: assert property (p_err) else $error("pslverr wrong");
   a_rd_ctl: assert property (p_rd_ctl) else $error("ctl bits");
   a_upd: assert property (p_upd) else $error("no update");
   a_upd_cause: assert property (p_upd_cause) else $error("bad update");
   a_ilk: assert property (p_ilk) else $error("interlock moved");
   a_pled: assert property (p_pled) else $error("power led moved");
endmodule : hpsc_slot_ctl_assertions

bind hpsc_slot_ctl hpsc_slot_ctl_assertions #(.AW(AW)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .power_led(power_led),
   .interlock_engaged(interlock_engaged), .slot_update(slot_update)
);

// >>> testbench/hpsc_slot_model.sv
// Purpose: slot controller that finishes each update after a delay
// Assumes: slot_update is a one-cycle pulse
// Notes: slow selects a long delay so pending commands can be seen
module hpsc_slot_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slot_update,
   input wire logic slow,
   output logic slot_ack
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] cnt_r;

   // count down from each update, pulse ack at the end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 6'h00;
         slot_ack <= 1'b0;
      end else begin
         slot_ack <= (cnt_r == 6'h01);
         if (slot_update) cnt_r <= slow ? 6'h14 : 6'h02;
         else if (cnt_r != 6'h00) cnt_r <= cnt_r - 6'h01;
      end
   end
endmodule : hpsc_slot_model

// >>> testbench/hpsc_slot_ctl_test.sv
// Purpose: register and event tests of the slot control block
// Assumes: APB answer after two access cycles, slot model acks
// Notes: sensors driven here, slot ack from the slot model
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module hpsc_slot_ctl_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rq;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, re, slot_ack, slow = 0;
   logic latch_open = 0, card_present = 0, link_active = 0;
   logic [1:0] attention_led, power_led;
   logic slot_power_off, interlock_engaged, slot_update, hp_irq, hp_wake;
   int failures = 0, n_compared = 0, sb[3] = '{2, 3, 8};

   // clock
   always #2.5 pclk = ~pclk;

   hpsc_slot_ctl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .latch_open(latch_open), .card_present(card_present),
      .link_active(link_active), .slot_ack(slot_ack),
      .attention_led(attention_led), .power_led(power_led),
      .slot_power_off(slot_power_off),
      .interlock_engaged(interlock_engaged), .slot_update(slot_update),
      .hp_irq(hp_irq), .hp_wake(hp_wake));
   hpsc_slot_model u_slot (.pclk(pclk), .presetn(presetn),
      .slot_update(slot_update), .slow(slow), .slot_ack(slot_ack));

   task automatic test_done;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         failures++;
         test_done();
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // control write as one command, waits for its done flag
   task automatic ctl(input logic [31:0] d);
      int n;
      wr(12'h008, 32'h10);
      wr(12'h000, d);
      if (slow) begin
         rd(12'h008);
         `CHK("done early", 1'b0, rq[4]);
      end
      n = 0;
      do begin
         rd(12'h008);
         n++;
      end while (rq[4] !== 1'b1 && n < 20);
      `CHK("done", 1'b1, rq[4]);
   endtask : ctl

   // main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("att rst", 2'h3, attention_led);
      `CHK("pwr rst", 2'h1, power_led);
      rd(12'h000);
      `CHK("ctl nocap", 32'h0, rq);
      ctl(32'hFFFF);
      rd(12'h000);
      `CHK("ctl gated", 32'h1008, rq);
      `CHK("pwr gated", 2'h1, power_led);
      `CHK("pwroff gated", 1'b0, slot_power_off);
      rd(12'h010);
      `CHK("unmapped err", 1'b1, re);
      `CHK("unmapped data", 32'h0, rq);
      wr(12'h004, 32'h2005E);
      slow <= 1'b1;
      ctl(32'h0FB0);
      slow <= 1'b0;
      rd(12'h000);
      `CHK("ctl rd", 32'h07B0, rq);
      `CHK("att", 2'h2, attention_led);
      `CHK("pwr", 2'h3, power_led);
      `CHK("pwroff", 1'b1, slot_power_off);
      `CHK("ilk", 1'b1, interlock_engaged);
      `CHK("cmd irq", 1'b1, hp_irq);
      ctl(32'h07B0);
      `CHK("ilk hold", 1'b1, interlock_engaged);
      `CHK("cmd irq again", 1'b1, hp_irq);
      wr(12'h008, 32'h10);
      repeat (2) @(posedge pclk);
      `CHK("irq clr", 1'b0, hp_irq);
      for (int i = 1; i < 4; i++) begin
         ctl(32'(i << 6 | i << 8 | 1 << 11));
         `CHK("att code", i, attention_led);
         `CHK("pwr code", i, power_led);
         `CHK("ilk tog", 1 - i % 2, interlock_engaged);
         `CHK("pwr on", 1'b0, slot_power_off);
      end
      wr(12'h00C, 32'h1);
      ctl(32'h02C0);
      `CHK("upstream pwr", 2'h3, power_led);
      wr(12'h00C, 32'h0);
      ctl(32'h102C);
      for (int k = 0; k < 3; k++) begin
         @(posedge pclk);
         case (k)
            0: latch_open <= ~latch_open;
            1: card_present <= ~card_present;
            default: link_active <= ~link_active;
         endcase
         repeat (5) @(posedge pclk);
         `CHK("wake", 1'b1, hp_wake);
         `CHK("irq", 1'b1, hp_irq);
         rd(12'h008);
         `CHK("flag", 1'b1, rq[sb[k]]);
         wr(12'h008, 32'(1 << sb[k]));
         repeat (2) @(posedge pclk);
         `CHK("irq off", 1'b0, hp_irq);
      end
      ctl(32'h100C);
      card_present <= ~card_present;
      repeat (5) @(posedge pclk);
      `CHK("wake nomaster", 1'b1, hp_wake);
      `CHK("irq nomaster", 1'b0, hp_irq);
      wr(12'h008, 32'h8);
      ctl(32'h0000);
      link_active <= ~link_active;
      repeat (5) @(posedge pclk);
      `CHK("wake off", 1'b0, hp_wake);
      rd(12'h008);
      `CHK("link flag", 1'b1, rq[8]);
      test_done();
   end
endmodule : hpsc_slot_ctl_test
